/* core/cdus_top.sv */
// Overview of operation
// - two independent 12-bit converters with own registers
// - each converter enabled separately, no cross effect
// - trigger select 111 updates on high write
// - low byte write only stored in write mode
// - high write moves both bytes same cycle
// - codes 000-011 update on timer 0-3 overflow
// - timers 2,3 use low or high overflow
// - codes 100-110 update on strobe rise/fall/either
// - four full-scale settings per converter
// - both enabled: separate pins or merged pin
// - justify bit chooses left or right mapping
// - full scale resets to 2 mA
// - merge set routes both onto first pin
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module cdus_top
  import cdus_pkg::*;
#(
  parameter int NUM_CONV = 2,
  parameter int CONV_W   = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [BYTE_W-1:0] wrData,
  input  wire logic              wrStrobe,
  input  wire logic              rdStrobe,
  output logic      [BYTE_W-1:0] rdData,
  input  wire logic              timer0Ovf,
  input  wire logic              timer1Ovf,
  input  wire logic              timer2LowOvf,
  input  wire logic              timer2HighOvf,
  input  wire logic              timer2EightBit,
  input  wire logic              timer3LowOvf,
  input  wire logic              timer3HighOvf,
  input  wire logic              timer3EightBit,
  input  wire logic              externalConvertStrobe,
  output logic      [1:0]        converterEnable,
  output logic      [1:0]        fullScaleZero,
  output logic      [1:0]        fullScaleOne,
  output logic      [CONV_W-1:0] latchZero,
  output logic      [CONV_W-1:0] latchOne,
  output logic      [1:0]        updatePulse,
  output logic                   pinZeroFromZero,
  output logic                   pinZeroFromOne,
  output logic                   pinOneFromOne
);

  if (NUM_CONV != 2 || CONV_W != 12) begin : gParamCheck
    $error("cdus_top serves exactly two 12-bit converters");
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstMeta_q;
  logic rstSyncB;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSyncB  <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncB  <= rstMeta_q;
    end
  end

  // ------------------------------------------------------------
  // strobe synchroniser and edge detect
  // ------------------------------------------------------------
  logic strobeMeta_q;
  logic strobeSync_q;
  logic strobePrev_q;
  logic strobeRise;
  logic strobeFall;

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      strobeMeta_q <= 1'b0;
      strobeSync_q <= 1'b0;
      strobePrev_q <= 1'b0;
    end else begin
      strobeMeta_q <= externalConvertStrobe;
      strobeSync_q <= strobeMeta_q;
      strobePrev_q <= strobeSync_q;
    end
  end

  // compares the two settled stages only, never the first one
  assign strobeRise = strobeSync_q & ~strobePrev_q;
  assign strobeFall = ~strobeSync_q & strobePrev_q;

  // ------------------------------------------------------------
  // timer events
  // ------------------------------------------------------------
  logic [3:0] timerEvt;

  assign timerEvt[0] = timer0Ovf;
  assign timerEvt[1] = timer1Ovf;
  assign timerEvt[2] = timer2EightBit ? timer2LowOvf : timer2HighOvf;
  assign timerEvt[3] = timer3EightBit ? timer3LowOvf : timer3HighOvf;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic [1:0]        wrCtrl;
  logic [1:0]        wrHigh;
  logic [1:0]        wrLow;
  logic [BYTE_W-1:0] ctrlReg  [NUM_CONV];
  logic [BYTE_W-1:0] highReg  [NUM_CONV];
  logic [BYTE_W-1:0] lowReg   [NUM_CONV];
  logic [CONV_W-1:0] latchReg [NUM_CONV];
  logic [BYTE_W-1:0] merge_q;

  assign wrCtrl[0] = wrStrobe && addr == OFS_CTRL_ZERO;
  assign wrHigh[0] = wrStrobe && addr == OFS_HIGH_ZERO;
  assign wrLow[0]  = wrStrobe && addr == OFS_LOW_ZERO;
  assign wrCtrl[1] = wrStrobe && addr == OFS_CTRL_ONE;
  assign wrHigh[1] = wrStrobe && addr == OFS_HIGH_ONE;
  assign wrLow[1]  = wrStrobe && addr == OFS_LOW_ONE;

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      merge_q <= MERGE_RESET;
    end else if (wrStrobe && addr == OFS_MERGE) begin
      merge_q <= {7'h00, wrData[MERGE_BIT]};
    end
  end

  // ------------------------------------------------------------
  // converter channels
  // ------------------------------------------------------------
  for (genvar gi = 0; gi < NUM_CONV; gi++) begin : gConv
    cdus_channel #(
      .CONV_W (CONV_W)
    ) cdus_channel_i (
      .clk         (clk),
      .rstB        (rstSyncB),
      .wrCtrl      (wrCtrl[gi]),
      .wrHigh      (wrHigh[gi]),
      .wrLow       (wrLow[gi]),
      .wrData      (wrData),
      .timerEvt    (timerEvt),
      .strobeRise  (strobeRise),
      .strobeFall  (strobeFall),
      .ctrlReg     (ctrlReg[gi]),
      .highReg     (highReg[gi]),
      .lowReg      (lowReg[gi]),
      .latchWord   (latchReg[gi]),
      .updatePulse (updatePulse[gi])
    );
    assign converterEnable[gi] = ctrlReg[gi][CTRL_EN_BIT];
  end

  // full-scale code goes straight to the analog range select
  assign fullScaleZero = ctrlReg[0][CTRL_FS_LSB +: 2];
  assign fullScaleOne  = ctrlReg[1][CTRL_FS_LSB +: 2];
  assign latchZero     = latchReg[0];
  assign latchOne      = latchReg[1];

  // ------------------------------------------------------------
  // output routing
  // ------------------------------------------------------------
  // second converter follows the merge bit even when the first is off
  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      pinZeroFromZero <= 1'b0;
      pinZeroFromOne  <= 1'b0;
      pinOneFromOne   <= 1'b0;
    end else begin
      pinZeroFromZero <= converterEnable[0];
      pinZeroFromOne  <= converterEnable[1] & merge_q[MERGE_BIT];
      pinOneFromOne   <= converterEnable[1] & ~merge_q[MERGE_BIT];
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [BYTE_W-1:0] rdMux;

  always_comb begin
    unique case (addr)
      OFS_CTRL_ZERO: rdMux = ctrlReg[0];
      OFS_HIGH_ZERO: rdMux = highReg[0];
      OFS_LOW_ZERO:  rdMux = lowReg[0];
      OFS_CTRL_ONE:  rdMux = ctrlReg[1];
      OFS_HIGH_ONE:  rdMux = highReg[1];
      OFS_LOW_ONE:   rdMux = lowReg[1];
      OFS_MERGE:     rdMux = merge_q;
      OFS_LATCH_H0:  rdMux = {4'h0, latchReg[0][11:8]};
      OFS_LATCH_L0:  rdMux = latchReg[0][7:0];
      OFS_LATCH_H1:  rdMux = {4'h0, latchReg[1][11:8]};
      OFS_LATCH_L1:  rdMux = latchReg[1][7:0];
      default:       rdMux = 8'h00;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      rdData <= rdMux;
    end else begin
      rdData <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncB);

  logic [2:0] modeZero;
  assign modeZero = ctrlReg[0][CTRL_CM_LSB +: 3];

  sequence highWriteZero_s;
    wrHigh[0] && modeZero == CM_WRITE && !ctrlReg[0][CTRL_RJ_BIT];
  endsequence

  sequence strobeUp_s;
    !strobeSync_q ##1 strobeSync_q;
  endsequence

  sequence strobeDown_s;
    strobeSync_q ##1 !strobeSync_q;
  endsequence

  writeTrigLatch_a: assert property (highWriteZero_s |=>
    latchZero == {$past(wrData), $past(lowReg[0][7:4])})
    else $error("high write did not load latch with held low byte");

  lowHoldOnly_a: assert property (
    wrLow[0] && !wrHigh[0] && modeZero == CM_WRITE |=> $stable(latchZero))
    else $error("low byte write changed the latch");

  timerZeroUpd_a: assert property (
    modeZero == CM_TIMER0 && timer0Ovf && !wrCtrl[0] |=> updatePulse[0]
      && latchZero == ($past(ctrlReg[0][CTRL_RJ_BIT])
        ? {$past(highReg[0][3:0]), $past(lowReg[0])}
        : {$past(highReg[0]), $past(lowReg[0][7:4])}) || $past(wrHigh[0] || wrLow[0]))
    else $error("timer 0 overflow did not copy held bytes");

  heldInTimer_a: assert property (
    modeZero == CM_TIMER1 && !timer1Ovf && (wrHigh[0] || wrLow[0]) |=> $stable(latchZero))
    else $error("data write passed through while held");

  timerTwoSel_a: assert property (
    modeZero == CM_TIMER2 && timer2EightBit && timer2HighOvf && !timer2LowOvf
      |=> !updatePulse[0])
    else $error("timer 2 high overflow used in 8-bit mode");

  strobeRisePulse_a: assert property (
    modeZero == CM_RISE ##0 strobeUp_s |=> updatePulse[0] ##1 !updatePulse[0])
    else $error("rising strobe edge gave no single update pulse");

  strobeSyncDelay_a: assert property (
    $rose(externalConvertStrobe) ##1 externalConvertStrobe |=> $rose(strobeSync_q))
    else $error("strobe synchroniser latency wrong");

  ctrlIndependent_a: assert property (wrCtrl[0] |=> $stable(ctrlReg[1]))
    else $error("control write of one converter touched the other");

  mergeRoute_a: assert property (
    converterEnable == 2'b11 && merge_q[MERGE_BIT] |=> pinZeroFromOne && !pinOneFromOne)
    else $error("merge did not route second converter to first pin");

  sepRoute_a: assert property (
    converterEnable == 2'b11 && !merge_q[MERGE_BIT] |=> pinOneFromOne && !pinZeroFromOne)
    else $error("outputs not separated with merge clear");

  resetScale_a: assert property ($rose(rstSyncB) |->
    fullScaleZero == FS_TWO_MA && fullScaleOne == FS_TWO_MA)
    else $error("full scale not 2 mA after reset");

  readLatency_a: assert property (
    rdStrobe && addr == OFS_HIGH_ONE |=> rdData == $past(highReg[1]) ##1
      (rdData == 8'h00 || $past(rdStrobe)))
    else $error("read data timing wrong");

  rightJustLatch_a: assert property (
    wrHigh[0] && modeZero == CM_WRITE && ctrlReg[0][CTRL_RJ_BIT] |=>
      latchZero == {$past(wrData[3:0]), $past(lowReg[0])})
    else $error("right-justified high write mapped the bits wrongly");

  strobeFallPulse_a: assert property (
    strobeDown_s ##0 modeZero == CM_FALL |=> updatePulse[0] ##1 !updatePulse[0])
    else $error("falling strobe edge gave no single update pulse");

  anyEdgePulse_a: assert property (
    modeZero == CM_ANY && strobeSync_q != strobePrev_q |=> updatePulse[0])
    else $error("strobe edge in either-edge mode gave no update");

  timerThreeSel_a: assert property (
    modeZero == CM_TIMER3 && timer3EightBit && timer3HighOvf && !timer3LowOvf
      |=> !updatePulse[0])
    else $error("timer 3 high overflow used in 8-bit mode");

  readIdle_a: assert property (!rdStrobe |=> rdData == 8'h00)
    else $error("read data shown without a read");

endmodule

/* core/cdus_pkg.sv */
package cdus_pkg;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 4;
  localparam int          BYTE_W        = 8;
  localparam logic [3:0]  OFS_CTRL_ZERO = 4'h0;
  localparam logic [3:0]  OFS_HIGH_ZERO = 4'h1;
  localparam logic [3:0]  OFS_LOW_ZERO  = 4'h2;
  localparam logic [3:0]  OFS_CTRL_ONE  = 4'h3;
  localparam logic [3:0]  OFS_HIGH_ONE  = 4'h4;
  localparam logic [3:0]  OFS_LOW_ONE   = 4'h5;
  localparam logic [3:0]  OFS_MERGE     = 4'h6;
  localparam logic [3:0]  OFS_LATCH_H0  = 4'h8;
  localparam logic [3:0]  OFS_LATCH_L0  = 4'h9;
  localparam logic [3:0]  OFS_LATCH_H1  = 4'hA;
  localparam logic [3:0]  OFS_LATCH_L1  = 4'hB;

  // ------------------------------------------------------------
  // converter_control layout
  // ------------------------------------------------------------
  localparam int          CTRL_EN_BIT   = 7;
  localparam int          CTRL_CM_LSB   = 4;
  localparam int          CTRL_RJ_BIT   = 2;
  localparam int          CTRL_FS_LSB   = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h73;
  localparam logic [7:0]  CTRL_WMASK    = 8'hF7;
  localparam logic [7:0]  HIGH_RESET    = 8'h00;
  localparam logic [7:0]  LOW_RESET     = 8'h00;
  localparam logic [7:0]  MERGE_RESET   = 8'h00;
  localparam int          MERGE_BIT     = 0;

  // ------------------------------------------------------------
  // update_trigger_select codes
  // ------------------------------------------------------------
  localparam logic [2:0]  CM_TIMER0     = 3'h0;
  localparam logic [2:0]  CM_TIMER1     = 3'h1;
  localparam logic [2:0]  CM_TIMER2     = 3'h2;
  localparam logic [2:0]  CM_TIMER3     = 3'h3;
  localparam logic [2:0]  CM_RISE       = 3'h4;
  localparam logic [2:0]  CM_FALL       = 3'h5;
  localparam logic [2:0]  CM_ANY        = 3'h6;
  localparam logic [2:0]  CM_WRITE      = 3'h7;

  // ------------------------------------------------------------
  // full_scale_select codes
  // ------------------------------------------------------------
  localparam logic [1:0]  FS_QUARTER_MA = 2'h0;
  localparam logic [1:0]  FS_HALF_MA    = 2'h1;
  localparam logic [1:0]  FS_ONE_MA     = 2'h2;
  localparam logic [1:0]  FS_TWO_MA     = 2'h3;

  localparam logic [11:0] LATCH_RESET   = 12'h000;

endpackage

/* core/cdus_channel.sv */
`timescale 1ns/1ns
module cdus_channel
  import cdus_pkg::*;
#(
  parameter int CONV_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rstB,
  input  wire logic              wrCtrl,
  input  wire logic              wrHigh,
  input  wire logic              wrLow,
  input  wire logic [BYTE_W-1:0] wrData,
  input  wire logic [3:0]        timerEvt,
  input  wire logic              strobeRise,
  input  wire logic              strobeFall,
  output logic      [BYTE_W-1:0] ctrlReg,
  output logic      [BYTE_W-1:0] highReg,
  output logic      [BYTE_W-1:0] lowReg,
  output logic      [CONV_W-1:0] latchWord,
  output logic                   updatePulse
);

  if (CONV_W != 12) begin : gWidthCheck
    $error("cdus_channel serves only a 12-bit converter");
  end

  logic [2:0]        mode;
  logic [BYTE_W-1:0] highD;
  logic [BYTE_W-1:0] lowD;
  logic [CONV_W-1:0] wordD;
  logic              trigger;

  assign mode = ctrlReg[CTRL_CM_LSB +: 3];

  // ------------------------------------------------------------
  // trigger selection
  // ------------------------------------------------------------
  always_comb begin
    unique case (mode)
      CM_TIMER0, CM_TIMER1,
      CM_TIMER2, CM_TIMER3: trigger = timerEvt[mode[1:0]];
      CM_RISE:              trigger = strobeRise;
      CM_FALL:              trigger = strobeFall;
      CM_ANY:               trigger = strobeRise | strobeFall;
      CM_WRITE:             trigger = wrHigh;
    endcase
  end

  // newest bytes, so a write in the trigger cycle is not missed
  assign highD = wrHigh ? wrData : highReg;
  assign lowD  = wrLow  ? wrData : lowReg;

  // justification picks where the 12 bits sit in the two bytes
  assign wordD = ctrlReg[CTRL_RJ_BIT] ? {highD[3:0], lowD}
                                      : {highD, lowD[7:4]};

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      ctrlReg <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlReg <= wrData & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      highReg <= HIGH_RESET;
      lowReg  <= LOW_RESET;
    end else begin
      highReg <= highD;
      lowReg  <= lowD;
    end
  end

  // high byte and held low byte land in the same edge
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      latchWord   <= LATCH_RESET;
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= trigger;
      if (trigger) begin
        latchWord <= wordD;
      end
    end
  end

endmodule

/* verif/cdus_event_model.sv */
`timescale 1ns/1ns
module cdus_event_model (
  input  wire logic       clk,
  output logic      [5:0] ovf,
  output logic            strobe
);
  // ------------------------------------------------------------
  // timer overflow lines and strobe pin
  // ------------------------------------------------------------
  // ovf: 0 t0, 1 t1, 2 t2 low, 3 t2 high, 4 t3 low, 5 t3 high
  initial begin
    ovf    = 6'h00;
    strobe = 1'b0;
  end

  // lag lets a slow timer answer late; pulse is exactly one cycle
  task automatic pulse(input int idx, input int lag);
    repeat (lag) @(posedge clk);
    @(posedge clk);
    ovf[idx] <= 1'b1;
    @(posedge clk);
    ovf[idx] <= 1'b0;
  endtask

  // pin is a plain level held between edges
  task automatic level(input logic v);
    @(posedge clk);
    strobe <= v;
  endtask
endmodule

/* verif/cdus_top_bench.sv */
`timescale 1ns/1ns
module cdus_top_bench;
  import cdus_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b, wrStrobe, rdStrobe, timer2EightBit, timer3EightBit;
  logic [3:0]  addr;
  logic [7:0]  wrData, rdData, d, h, l, r;
  logic [5:0]  ovf;
  logic        strobe, rj, eight;
  logic [1:0]  converterEnable, fullScaleZero, fullScaleOne, updatePulse;
  logic [11:0] latchZero, latchOne, ex, held;
  logic        pinZeroFromZero, pinZeroFromOne, pinOneFromOne;
  logic [15:0] lfsrQ = 16'h2D67;
  int          err_total, check_count, ch, startCnt, pulseCnt [2];
  logic [3:0]  ofsCtrl [2] = '{OFS_CTRL_ZERO, OFS_CTRL_ONE};
  logic [3:0]  ofsHigh [2] = '{OFS_HIGH_ZERO, OFS_HIGH_ONE};
  logic [3:0]  ofsLow  [2] = '{OFS_LOW_ZERO, OFS_LOW_ONE};
  logic [3:0]  ofsLatH [2] = '{OFS_LATCH_H0, OFS_LATCH_H1};
  logic [3:0]  ofsLatL [2] = '{OFS_LATCH_L0, OFS_LATCH_L1};

  always #25 clk = ~clk;

  cdus_top cdus_top_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .timer0Ovf(ovf[0]),
    .timer1Ovf(ovf[1]), .timer2LowOvf(ovf[2]), .timer2HighOvf(ovf[3]),
    .timer2EightBit(timer2EightBit), .timer3LowOvf(ovf[4]), .timer3HighOvf(ovf[5]),
    .timer3EightBit(timer3EightBit), .externalConvertStrobe(strobe),
    .converterEnable(converterEnable), .fullScaleZero(fullScaleZero),
    .fullScaleOne(fullScaleOne), .latchZero(latchZero), .latchOne(latchOne),
    .updatePulse(updatePulse), .pinZeroFromZero(pinZeroFromZero),
    .pinZeroFromOne(pinZeroFromOne), .pinOneFromOne(pinOneFromOne));

  cdus_event_model cdus_event_model_i (.clk(clk), .ovf(ovf), .strobe(strobe));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (updatePulse[i] === 1'b1) pulseCnt[i]++;
    end
  end

  function automatic logic [7:0] rnd();
    lfsrQ = {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
    return lfsrQ[7:0];
  endfunction

  function automatic logic [11:0] exp_word(logic j, logic [7:0] hi, logic [7:0] lo);
    return j ? {hi[3:0], lo} : {hi, lo[7:4]};
  endfunction

  function automatic logic [11:0] latch_of(int c);
    return c ? latchOne : latchZero;
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr     <= a;
    wrData   <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask

  // waits bounded, then checks one pulse, both latches and readback
  task automatic expect_update(input int c, input logic [11:0] e, input int b);
    logic [11:0] other;
    logic [7:0]  v;
    int          n;
    other = latch_of(1 - c);
    n = 0;
    while (pulseCnt[c] == b && n < 10) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk(latch_of(c), e);
    chk(latch_of(1 - c), other);
    rd(ofsLatH[c], v);
    chk({4'h0, v}, {8'h00, e[11:8]});
    rd(ofsLatL[c], v);
    chk({4'h0, v}, {4'h0, e[7:0]});
    chk(12'(pulseCnt[c] - b), 12'h001);
  endtask

  task automatic expect_none(input int c, input int b, input logic [11:0] e);
    repeat (6) @(posedge clk);
    #1;
    chk(12'(pulseCnt[c] - b), 12'h000);
    chk(latch_of(c), e);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_b, wrStrobe, rdStrobe, timer2EightBit, timer3EightBit} = 5'h00;
    addr   = 4'h0;
    wrData = 8'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk({4'h0, d}, (a == 0 || a == 3) ? 12'h073 : 12'h000);
    end
    chk({8'h00, fullScaleZero, fullScaleOne}, 12'h00F);
    for (int f = 0; f < 4; f++) begin
      wr(OFS_CTRL_ZERO, {4'h7, 2'h2, 2'(f)});
      rd(OFS_CTRL_ZERO, d);
      chk({4'h0, d}, {4'h0, 4'h7, 2'h0, 2'(f)});
      chk({10'h000, fullScaleZero}, 12'(f));
    end
    wr(OFS_CTRL_ONE, 8'hF3);
    #1 chk({10'h000, converterEnable}, 12'h002);
    wr(OFS_CTRL_ZERO, 8'hF3);
    #1 chk({10'h000, converterEnable}, 12'h003);
    wr(OFS_MERGE, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({9'h000, pinZeroFromZero, pinZeroFromOne, pinOneFromOne}, 12'h006);
    wr(OFS_MERGE, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({9'h000, pinZeroFromZero, pinZeroFromOne, pinOneFromOne}, 12'h005);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      ch = r[0];
      rj = r[1];
      h = rnd();
      l = rnd();
      wr(ofsCtrl[ch], {1'b1, CM_WRITE, 1'b0, rj, r[3:2]});
      startCnt = pulseCnt[ch];
      held = latch_of(ch);
      wr(ofsLow[ch], ~l);
      wr(ofsLow[ch], l);
      expect_none(ch, startCnt, held);
      wr(ofsHigh[ch], h);
      expect_update(ch, exp_word(rj, h, l), startCnt);
    end
    wr(OFS_CTRL_ZERO, {1'b1, CM_WRITE, 4'h3});
    wr(OFS_LOW_ZERO, 8'h00);
    for (int i = 0; i < 3; i++) begin
      h = rnd();
      startCnt = pulseCnt[0];
      wr(OFS_HIGH_ZERO, h);
      expect_update(0, {h, 4'h0}, startCnt);
    end
    for (int c = 0; c < 7; c++) begin
      for (int k = 0; k < 3; k++) begin
        r = rnd();
        // first passes pin channel and timer width so each of codes 000-110 is seen on both
        ch = (k == 0) ? 0 : (k == 1) ? 1 : int'(r[0]);
        rj = r[1];
        eight = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : r[2];
        h = rnd();
        l = rnd();
        @(posedge clk);
        timer2EightBit <= eight;
        timer3EightBit <= eight;
        wr(ofsCtrl[ch], {1'b1, 3'(c), 1'b0, rj, 2'h3});
        if (c >= 4) begin
          cdus_event_model_i.level(c == 5);
          repeat (6) @(posedge clk);
        end
        startCnt = pulseCnt[ch];
        held = latch_of(ch);
        wr(ofsLow[ch], l);
        wr(ofsHigh[ch], h);
        if (c == 0) cdus_event_model_i.pulse(1, 0);
        else if (c == 2) cdus_event_model_i.pulse(eight ? 3 : 2, 0);
        else if (c == 3) cdus_event_model_i.pulse(eight ? 5 : 4, 0);
        else cdus_event_model_i.pulse(0, 0);
        expect_none(ch, startCnt, held);
        ex = exp_word(rj, h, l);
        if (c < 2) cdus_event_model_i.pulse(c, int'(r[4:3]));
        else if (c == 2) cdus_event_model_i.pulse(eight ? 2 : 3, int'(r[4:3]));
        else if (c == 3) cdus_event_model_i.pulse(eight ? 4 : 5, int'(r[4:3]));
        else cdus_event_model_i.level(c != 5);
        expect_update(ch, ex, startCnt);
        if (c == 6) begin
          startCnt = pulseCnt[ch];
          cdus_event_model_i.level(1'b0);
          expect_update(ch, ex, startCnt);
        end
      end
    end
    results;
  end
endmodule
